// ===== hdl/ufc_checker.v
// frame parser, checksum checker, response builder and fault pin logic
`timescale 1ns/1ps
`include "ufc_defines.vh"
module ufc_checker #(
  parameter NODE_SETTLE_CYC = `UFC_NODE_SETTLE_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output reg rx_ready,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  input wire [1:0] node_strap_pin_0,
  input wire [1:0] node_strap_pin_1,
  input wire [1:0] node_strap_pin_2,
  input wire [3:0] fault_report_delay,
  output reg reg_wr_en,
  input wire reg_wr_ready,
  output reg reg_rd_en,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  output reg update_pulse,
  output reg regs_reset_pulse,
  output reg fault_pin_n_out,
  output reg fault_pin_n_oe
);

  // ----------------------------------------
  // states, one-hot
  // ----------------------------------------
  localparam ST_HDR = 9'h001;
  localparam ST_ID = 9'h002;
  localparam ST_ADDR = 9'h004;
  localparam ST_DATA = 9'h008;
  localparam ST_CRCL = 9'h010;
  localparam ST_CRCH = 9'h020;
  localparam ST_WRITE = 9'h040;
  localparam ST_RESP = 9'h080;
  localparam ST_ACK = 9'h100;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // one byte through the reflected checksum, lsb first
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] b;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
        c = c[0] ? ((c >> 1) ^ `UFC_CRC_POLY) : (c >> 1);
      crc_byte = c;
    end
  endfunction

  // bit reversal of one byte
  function [7:0] rev8;
    input [7:0] b;
    integer i;
    begin
      rev8 = 8'h00;
      for (i = 0; i < 8; i = i + 1)
        rev8[i] = b[7-i];
    end
  endfunction

  // length code to byte count, zero for special or unknown codes
  function [5:0] data_len;
    input [4:0] code;
    begin
      if (!code[4])
        data_len = {2'b00, code[3:0]} + 6'h01;
      else if (code == `UFC_CODE_LEN32)
        data_len = 6'h20;
      else
        data_len = 6'h00;
    end
  endfunction

  // node number with its two parity bits
  function [7:0] id_byte;
    input [5:0] n;
    begin
      id_byte = {~(n[1] ^ n[3] ^ n[4] ^ n[5]), n[0] ^ n[1] ^ n[2] ^ n[4], n};
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [8:0] state_reg; // parser state
  reg [7:0] hdr_reg; // header of the frame in flight
  reg [7:0] id_reg; // id byte of the frame in flight
  reg [7:0] cur_addr_reg; // running register address
  reg [5:0] left_reg; // data bytes still to come or to move
  reg [5:0] resp_idx_reg; // byte index inside a read response
  reg [15:0] crc_reg; // running checksum, rx or tx
  reg crc_lo_ok_reg; // low checksum byte matched
  reg ack_pend_reg; // acknowledge owed after the write
  reg [1:0] rd_stage_reg; // read pipeline: 2 issued, 1 data due
  reg rd_local_reg; // the pending read hits a local register
  reg [7:0] rd_local_val_reg; // value of that local register
  reg [7:0] sys_conf_reg; // system_configuration
  reg crc_flag_reg; // checksum_fault_flag, latched
  reg [7:0] crc_cnt_reg; // checksum_error_counter
  reg [11:0] flt_cnt_reg; // fault pin delay counter
  reg fifo_flush;
  wire [5:0] node_number;
  wire node_ready;
  wire fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire fifo_out_valid;

  // header field decode
  wire hdr_cmd = hdr_reg[`UFC_HDR_KIND_BIT];
  wire hdr_read = hdr_reg[`UFC_HDR_READ_BIT];
  wire hdr_bc = hdr_reg[`UFC_HDR_BCAST_BIT];
  wire [4:0] hdr_code = hdr_reg[4:0];
  wire hdr_special = (hdr_code == `UFC_CODE_UPDATE) | (hdr_code == `UFC_CODE_REGRST);
  wire code_ok = (data_len(hdr_code) != 6'h00) | (hdr_special & ~hdr_read);
  wire [7:0] own_id = id_byte(node_number);
  // single device target: exact id incl. parity, so a parity error never matches
  wire to_self = node_ready & ~hdr_bc & (id_reg == own_id);
  // broadcast accepted only with the fixed id and a write
  wire to_all = hdr_bc & (id_reg == `UFC_BCAST_ID) & ~hdr_read;
  wire rx_take = rx_valid & rx_ready;
  wire tx_free = ~tx_valid | tx_ready;
  wire crc_good = crc_lo_ok_reg & (rx_data == crc_reg[15:8]);
  wire frame_act = hdr_cmd & code_ok & crc_good & (to_self | to_all);
  wire fifo_pop = fifo_out_valid & reg_wr_ready & (state_reg == ST_WRITE);
  wire [7:0] resp_byte = (resp_idx_reg == 6'h00) ? {3'b000, hdr_code} : own_id;
  wire [31:0] flt_prod = fault_report_delay * `UFC_DELAY_UNIT_CYC; // at most 1875, fits 12 bits
  // code zero still needs one cycle of steady difference
  wire [11:0] flt_target = (fault_report_delay == 4'h0) ? 12'h001 : flt_prod[11:0];

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ufc_node_strap #(
    .SETTLE_CYC(NODE_SETTLE_CYC)
  ) u_strap (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .node_strap_pin_0(node_strap_pin_0),
    .node_strap_pin_1(node_strap_pin_1),
    .node_strap_pin_2(node_strap_pin_2),
    .node_number(node_number),
    .node_ready(node_ready)
  );

  // write payload waits here until the checksum clears it
  ufc_fifo #(
    .WIDTH(8),
    .DEPTH(`UFC_FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .flush(fifo_flush),
    .in_data(rx_data),
    .in_valid(rx_take & (state_reg == ST_DATA)),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(reg_wr_ready & (state_reg == ST_WRITE))
  );

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  // parses every frame on the line, ours or not, so the byte count stays in step
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_HDR;
      hdr_reg <= 8'h00;
      id_reg <= 8'h00;
      cur_addr_reg <= 8'h00;
      left_reg <= 6'h00;
      resp_idx_reg <= 6'h00;
      crc_reg <= 16'h0000;
      crc_lo_ok_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      rd_stage_reg <= 2'b00;
      rd_local_reg <= 1'b0;
      rd_local_val_reg <= 8'h00;
      sys_conf_reg <= `UFC_SYS_CONF_RESET;
      crc_flag_reg <= 1'b0;
      crc_cnt_reg <= 8'h00;
      fifo_flush <= 1'b0;
      rx_ready <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      update_pulse <= 1'b0;
      regs_reset_pulse <= 1'b0;
    end
    else
    begin
      // pulses default low
      fifo_flush <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      update_pulse <= 1'b0;
      regs_reset_pulse <= 1'b0;
      if (tx_valid & tx_ready)
        tx_valid <= 1'b0;
      case (state_reg)
        ST_HDR:
        begin
          if (rx_take)
          begin
            hdr_reg <= rx_data;
            crc_reg <= crc_byte(16'h0000, rx_data);
            state_reg <= ST_ID;
          end
        end
        ST_ID:
        begin
          if (rx_take)
          begin
            id_reg <= rx_data;
            crc_reg <= crc_byte(crc_reg, rx_data);
            // start address only in plain read/write commands
            if (hdr_cmd & ~hdr_special)
              state_reg <= ST_ADDR;
            else if (~hdr_cmd & (data_len(hdr_code) != 6'h00))
              state_reg <= ST_DATA;
            else
              state_reg <= ST_CRCL;
            left_reg <= data_len(hdr_code);
          end
        end
        ST_ADDR:
        begin
          if (rx_take)
          begin
            cur_addr_reg <= rx_data; // one byte, first register
            crc_reg <= crc_byte(crc_reg, rx_data);
            // read commands carry the count in the header but no data bytes
            state_reg <= (hdr_read | (left_reg == 6'h00)) ? ST_CRCL : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (rx_take)
          begin
            crc_reg <= crc_byte(crc_reg, rx_data);
            left_reg <= left_reg - 6'h01;
            if (left_reg == 6'h01)
              state_reg <= ST_CRCL; // exactly the coded count
          end
        end
        ST_CRCL:
        begin
          if (rx_take)
          begin
            crc_lo_ok_reg <= (rx_data == crc_reg[7:0]); // low byte first
            state_reg <= ST_CRCH;
          end
        end
        ST_CRCH:
        begin
          if (rx_take)
          begin
            left_reg <= data_len(hdr_code);
            resp_idx_reg <= 6'h00;
            crc_reg <= 16'h0000;
            ack_pend_reg <= to_self & sys_conf_reg[`UFC_ACK_EN_BIT];
            if (hdr_cmd & ~crc_good & (crc_cnt_reg != 8'hFF))
              crc_cnt_reg <= crc_cnt_reg + 8'h01;
            if (frame_act & ~hdr_read & ~hdr_special)
              state_reg <= ST_WRITE;
            else if (frame_act & hdr_special)
            begin
              update_pulse <= (hdr_code == `UFC_CODE_UPDATE);
              regs_reset_pulse <= (hdr_code == `UFC_CODE_REGRST);
              if (hdr_code == `UFC_CODE_REGRST)
                sys_conf_reg <= `UFC_SYS_CONF_RESET;
              state_reg <= (to_self & sys_conf_reg[`UFC_ACK_EN_BIT]) ? ST_ACK : ST_HDR;
            end
            else if (frame_act & hdr_read & to_self)
              state_reg <= ST_RESP;
            else
            begin
              // foreign, failed or broadcast read frames write nothing; a failed command still counts and sets the flag
              fifo_flush <= 1'b1;
              state_reg <= ST_HDR;
            end
          end
        end
        ST_WRITE:
        begin
          if (fifo_pop)
          begin
            cur_addr_reg <= cur_addr_reg + 8'h01;
            left_reg <= left_reg - 6'h01;
            reg_addr <= cur_addr_reg;
            reg_wdata <= fifo_out_data;
            if (cur_addr_reg == `UFC_ADDR_SYS_CONF)
              sys_conf_reg <= fifo_out_data;
            else if ((cur_addr_reg != `UFC_ADDR_FAULT_FLAGS) & (cur_addr_reg != `UFC_ADDR_CRC_CNT))
              reg_wr_en <= 1'b1;
            if (left_reg == 6'h01)
              state_reg <= ack_pend_reg ? ST_ACK : ST_HDR;
          end
        end
        ST_RESP:
        begin
          if (rd_stage_reg == 2'b10)
            rd_stage_reg <= 2'b01;
          else if (rd_stage_reg == 2'b01)
          begin
            // read data arrive here, tx stage is known empty
            rd_stage_reg <= 2'b00;
            tx_data <= rd_local_reg ? rd_local_val_reg : reg_rdata;
            tx_valid <= 1'b1;
            crc_reg <= crc_byte(crc_reg, rd_local_reg ? rd_local_val_reg : reg_rdata);
            resp_idx_reg <= resp_idx_reg + 6'h01;
          end
          else if (tx_free)
          begin
            if (resp_idx_reg < 6'h02)
            begin
              tx_data <= resp_byte;
              tx_valid <= 1'b1;
              crc_reg <= crc_byte(crc_reg, resp_byte);
              resp_idx_reg <= resp_idx_reg + 6'h01;
            end
            else if (resp_idx_reg < left_reg + 6'h02)
            begin
              // fetch the next register, local ones served from here
              reg_addr <= cur_addr_reg;
              cur_addr_reg <= cur_addr_reg + 8'h01;
              rd_stage_reg <= 2'b10;
              rd_local_reg <= (cur_addr_reg == `UFC_ADDR_SYS_CONF) | (cur_addr_reg == `UFC_ADDR_FAULT_FLAGS)
                | (cur_addr_reg == `UFC_ADDR_CRC_CNT);
              rd_local_val_reg <= (cur_addr_reg == `UFC_ADDR_SYS_CONF) ? sys_conf_reg
                : (cur_addr_reg == `UFC_ADDR_FAULT_FLAGS) ? {7'h00, crc_flag_reg} : crc_cnt_reg;
              reg_rd_en <= ~((cur_addr_reg == `UFC_ADDR_SYS_CONF) | (cur_addr_reg == `UFC_ADDR_FAULT_FLAGS)
                | (cur_addr_reg == `UFC_ADDR_CRC_CNT));
            end
            else if (resp_idx_reg == left_reg + 6'h02)
            begin
              // checksum goes out bit-reversed, low byte first
              tx_data <= rev8(crc_reg[7:0]);
              tx_valid <= 1'b1;
              resp_idx_reg <= resp_idx_reg + 6'h01;
            end
            else
            begin
              tx_data <= rev8(crc_reg[15:8]);
              tx_valid <= 1'b1;
              state_reg <= ST_HDR;
            end
          end
        end
        ST_ACK:
        begin
          if (tx_free)
          begin
            tx_data <= `UFC_ACK_BYTE;
            tx_valid <= 1'b1;
            state_reg <= ST_HDR;
          end
        end
        default:
        begin
          state_reg <= ST_HDR;
        end
      endcase
      // fault flag: a new checksum error beats a clear in the same cycle
      if ((state_reg == ST_CRCH) & rx_take & hdr_cmd & ~crc_good)
        crc_flag_reg <= 1'b1;
      else if (fifo_pop & (cur_addr_reg == `UFC_ADDR_FAULT_FLAGS) & ~fifo_out_data[`UFC_CK_FAULT_BIT])
        crc_flag_reg <= 1'b0;
      // accept bytes only in parse states, after the node number is known;
      // the high checksum byte must still be taken, the gate closes right after it
      rx_ready <= node_ready & fifo_in_ready
        & ((state_reg & (ST_HDR | ST_ID | ST_ADDR | ST_DATA | ST_CRCL | ST_CRCH)) != 9'h000)
        & ~((state_reg == ST_CRCH) & rx_take);
    end
  end

  // ----------------------------------------
  // fault pin, open drain, follows the flag after the programmed delay
  // ----------------------------------------
  // the delay counts from each change of the flag, so a short glitch never reaches the pin
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flt_cnt_reg <= 12'h000;
      fault_pin_n_out <= 1'b0;
      fault_pin_n_oe <= 1'b0;
    end
    else
    begin
      fault_pin_n_out <= 1'b0; // only ever pulls low
      if (fault_pin_n_oe != crc_flag_reg)
      begin
        if (flt_cnt_reg >= flt_target - 12'h001)
        begin
          fault_pin_n_oe <= crc_flag_reg;
          flt_cnt_reg <= 12'h000;
        end
        else
          flt_cnt_reg <= flt_cnt_reg + 12'h001;
      end
      else
        flt_cnt_reg <= 12'h000;
    end
  end

endmodule

// ===== hdl/ufc_defines.vh
// constants for the frame checker: register offsets, field positions, codes and timing
//
// What this block does
// - broadcast needs id 0xBF, write only
// - up to 32 registers, address increments
// - start address is one byte
// - start address only in read/write commands
// - header length code sets data count
// - crc-16 reflected, 0xa001, start zero
// - checksum low byte first, high second
// - count failing command checksums, saturating at 0xFF
// - checksum fail sets flag, delayed fault pin
// - flag latched until host writes zero
// - pin released after delay once cleared
// - read response carries appended checksum
// - acknowledge byte is 0x7F
// - acknowledge only with enable bit set
// - no acknowledge on checksum/parity error
// - no acknowledge for broadcast writes
// - id byte: two parity bits, six-bit node
// - node number from three strap pins
// - header: kind, read, broadcast, length code
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UFC_ADDR_SYS_CONF 8'h4A
`define UFC_ADDR_FAULT_FLAGS 8'h57
`define UFC_ADDR_CRC_CNT 8'h59
`define UFC_SYS_CONF_RESET 8'h00
`define UFC_ACK_EN_BIT 3
`define UFC_CK_FAULT_BIT 0

// ----------------------------------------
// frame codes
// ----------------------------------------
`define UFC_BCAST_ID 8'hBF
`define UFC_ACK_BYTE 8'h7F
`define UFC_CRC_POLY 16'hA001
`define UFC_CODE_LEN32 5'h10
`define UFC_CODE_UPDATE 5'h18
`define UFC_CODE_REGRST 5'h1E
`define UFC_HDR_KIND_BIT 7
`define UFC_HDR_READ_BIT 6
`define UFC_HDR_BCAST_BIT 5

// ----------------------------------------
// timing
// ----------------------------------------
`define UFC_CLK_PERIOD_NS 8
`define UFC_NODE_SETTLE_NS 3000000
`define UFC_NODE_SETTLE_CYC ((`UFC_NODE_SETTLE_NS + `UFC_CLK_PERIOD_NS - 1) / `UFC_CLK_PERIOD_NS)
`define UFC_DELAY_UNIT_NS 1000
`define UFC_DELAY_UNIT_CYC (`UFC_DELAY_UNIT_NS / `UFC_CLK_PERIOD_NS)
`define UFC_FIFO_DEPTH 32

`endif

// ===== hdl/ufc_fifo.v
// byte fifo holding write data until the frame checksum is known
`timescale 1ns/1ps
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire arst_n,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // payload words
  reg [AW-1:0] wr_ptr_reg; // next slot to fill
  reg [AW-1:0] rd_ptr_reg; // next slot to drain
  reg [AW:0] count_reg; // words in memory, not counting the output stage
  wire push = in_valid & in_ready;
  wire load = (count_reg != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  // memory write port, no reset needed on data
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers, registered output stage and honest full flag
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      in_ready <= 1'b1;
    end
    else if (flush)
    begin
      // drop everything, frame was rejected
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (load)
      begin
        out_data <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      // full looks one word ahead so a push never lands on a full memory
      in_ready <= (count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load}) < DEPTH;
    end
  end

endmodule

// ===== hdl/ufc_node_strap.v
// strap sampler: synchronises the three strap pins and latches the node number after settling
`timescale 1ns/1ps
module ufc_node_strap #(
  parameter SETTLE_CYC = 375000
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [1:0] node_strap_pin_0,
  input wire [1:0] node_strap_pin_1,
  input wire [1:0] node_strap_pin_2,
  output reg [5:0] node_number,
  output reg node_ready
);

  // ----------------------------------------
  // two-stage synchroniser, stage one feeds only stage two
  // ----------------------------------------
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg [19:0] settle_cnt_reg; // counts the detection window

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      settle_cnt_reg <= 20'h00000;
      node_number <= 6'h00;
      node_ready <= 1'b0;
    end
    else
    begin
      // pin 0 gives node bits 5:4, pin 1 bits 3:2, pin 2 bits 1:0
      sync1_reg <= {node_strap_pin_0, node_strap_pin_1, node_strap_pin_2};
      sync2_reg <= sync1_reg;
      if (!node_ready)
      begin
        // the strap level is caught only once the detection time is over
        if (settle_cnt_reg >= SETTLE_CYC[19:0] - 20'h00001)
        begin
          node_number <= sync2_reg;
          node_ready <= 1'b1;
        end
        else
          settle_cnt_reg <= settle_cnt_reg + 20'h00001;
      end
    end
  end

endmodule

// ===== test/ufc_checker_checker.sv
// assertion monitor on the frame checker ports
`timescale 1ns/1ps
module ufc_assert_mon #(
  parameter NODE_SETTLE_CYC = 20
) (
  input wire clk_sys,
  input wire arst_n,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire update_pulse,
  input wire regs_reset_pulse,
  input wire fault_pin_n_out,
  input wire fault_pin_n_oe
);
  // edges since reset release, saturating so it never wraps
  reg [31:0] up_reg;
  always @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      up_reg <= 32'h0;
    else if (up_reg != 32'hFFFFFFFF)
      up_reg <= up_reg + 32'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_settle_hold: assert property (rx_ready |-> up_reg >= NODE_SETTLE_CYC)
    else $error("byte accepted before node number settled");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed before taken");
  a_pin_low: assert property (fault_pin_n_out == 1'b0)
    else $error("fault pin driven high");
  a_wr_local: assert property (reg_wr_en |-> !(reg_addr inside {8'h4A, 8'h57, 8'h59}))
    else $error("local register write passed outward");
  a_rd_local: assert property (reg_rd_en |-> !(reg_addr inside {8'h4A, 8'h57, 8'h59}))
    else $error("local register read passed outward");
  a_wr_step: assert property (reg_wr_en && $past(reg_wr_en) |-> reg_addr == $past(reg_addr) + 8'h01)
    else $error("write address did not step by one");
  a_rd_gap: assert property (reg_rd_en |=> !reg_rd_en)
    else $error("read strobe longer than one cycle");
  a_upd_pulse: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse too long");
  a_one_special: assert property (!(update_pulse && regs_reset_pulse))
    else $error("two special pulses at once");
  c_ack: cover property (tx_valid && tx_ready && tx_data == 8'h7F);
  c_burst: cover property (reg_wr_en && $past(reg_wr_en));
  c_fault: cover property ($rose(fault_pin_n_oe));
endmodule

bind ufc_checker ufc_assert_mon #(.NODE_SETTLE_CYC(NODE_SETTLE_CYC)) ufc_assert_mon_inst (.*);

// ===== test/ufc_host_model.sv
// host side model: offers frame bytes, takes replies with random stalls
`timescale 1ns/1ps
module ufc_host_model (
  input wire clk_sys,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$]; // bytes returned by the device
  integer s = 32'h0436; // stall pattern seed
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // back-pressure on replies so hold behaviour is exercised
  always @(negedge clk_sys)
    tx_ready <= $random(s) % 3 != 0;
  always @(posedge clk_sys)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  // one byte held until taken; afterwards the line shows its complement
  task send(input [7:0] b);
    @(negedge clk_sys);
    rx_data = b;
    rx_valid = 1'b1;
    while (!rx_ready)
      @(negedge clk_sys);
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
endmodule

// ===== test/uart_frame_crc_ack_checker_bench.sv
// self-checking bench for the frame checker
`timescale 1ns/1ps
module uart_frame_crc_ack_checker_bench;
  localparam SETTLE = 20;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr_ready = 1'b1, ackon;
  logic [7:0] rx_data, tx_data, reg_addr, reg_wdata, me, f[$], wa[$], wd[$], e[$];
  logic [7:0] reg_rdata = 8'h00;
  logic rx_valid, rx_ready, tx_valid, tx_ready, reg_wr_en, reg_rd_en;
  logic update_pulse, regs_reset_pulse, fault_pin_n_out, fault_pin_n_oe;
  logic [1:0] node_strap_pin_0, node_strap_pin_1, node_strap_pin_2;
  logic [3:0] fault_report_delay = 4'h1;
  logic [5:0] node;
  integer errors = 0, n_compared = 0, seed = 32'h0436, cyc = 0, n_upd = 0, n_rst = 0, i;
  always #4 clk_sys = ~clk_sys;
  ufc_checker #(.NODE_SETTLE_CYC(SETTLE)) ufc_checker_inst (.*);
  ufc_host_model ufc_host_model_inst (.*);
  // outer register file: logs writes, answers reads, stalls at random
  always @(posedge clk_sys)
    if (reg_wr_en)
    begin
      wa.push_back(reg_addr);
      wd.push_back(reg_wdata);
    end
  always @(negedge clk_sys)
  begin
    cyc = cyc + 1;
    if (reg_rd_en)
      reg_rdata <= reg_addr ^ 8'h5A;
    reg_wr_ready <= $random(seed) % 4 != 0;
    n_upd = n_upd + update_pulse;
    n_rst = n_rst + regs_reset_pulse;
    if (cyc == 20000)
    begin
      errors++;
      end_sim;
    end
  end
  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function [15:0] crc(input logic [7:0] q[$]);
    crc = 16'h0000;
    foreach (q[k])
    begin
      crc = crc ^ {8'h00, q[k]};
      for (int j = 0; j < 8; j++)
        crc = (crc >> 1) ^ (crc[0] ? 16'hA001 : 16'h0000);
    end
  endfunction
  function [7:0] rev(input [7:0] b);
    for (int j = 0; j < 8; j++)
      rev[j] = b[7-j];
  endfunction
  function [7:0] idb(input [5:0] n);
    idb = {~(n[1] ^ n[3] ^ n[4] ^ n[5]), n[0] ^ n[1] ^ n[2] ^ n[4], n};
  endfunction
  function [4:0] lc(input int n);
    lc = n == 32 ? 5'h10 : 5'(n - 1);
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // header, id, body in f, checksum low byte first; then wait until quiet
  task frame(input [7:0] h, input [7:0] id, input bad);
    logic [15:0] c;
    f.push_front(id);
    f.push_front(h);
    c = crc(f) ^ {15'h0, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    wa = {};
    wd = {};
    ufc_host_model_inst.got = {};
    foreach (f[k])
      ufc_host_model_inst.send(f[k]);
    f = {};
    repeat (4) @(negedge clk_sys);
    for (i = 0; i < 300 && !(rx_ready && !tx_valid); i++)
      @(negedge clk_sys);
    if (i == 300)
      errors++;
  endtask
  task wr(input [7:0] id, input [7:0] a, input int n, input bc, input bad);
    logic ok;
    ok = !bad && (id == me || bc && id == 8'hBF);
    e = {};
    f = {a};
    for (int k = 0; k < n; k++)
    begin
      e.push_back($random(seed));
      f.push_back(e[k]);
    end
    frame({2'b10, bc, lc(n)}, id, bad);
    chk(16'(wa.size()), ok ? 16'(n) : 16'h0);
    if (ok)
      foreach (e[k]) chk({wa[k], wd[k]}, {a + 8'(k), e[k]});
    chk(16'(ufc_host_model_inst.got.size()), {15'h0, ok && ackon && !bc});
    if (ok && ackon && !bc)
      chk(ufc_host_model_inst.got[0], 8'h7F);
  endtask
  // e holds the expected data bytes on entry
  task rd(input [7:0] a, input int n);
    logic [15:0] c;
    e.push_front(me);
    e.push_front({3'b000, lc(n)});
    c = crc(e);
    e.push_back(rev(c[7:0]));
    e.push_back(rev(c[15:8]));
    f = {a};
    frame({3'b110, lc(n)}, me, 1'b0);
    chk(16'(ufc_host_model_inst.got.size()), 16'(e.size()));
    foreach (e[k]) chk(ufc_host_model_inst.got[k], e[k]);
  endtask
  initial
  begin
    {node_strap_pin_0, node_strap_pin_1, node_strap_pin_2} = $random(seed);
    if (node_strap_pin_2 == 2'h3)
      node_strap_pin_2 = 2'h1;
    node = {node_strap_pin_0, node_strap_pin_1, node_strap_pin_2};
    me = idb(node);
    ackon = 1'b0;
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (SETTLE + 4) @(negedge clk_sys);
    e = {8'h00};
    rd(8'h4A, 1);
    wr(me, 8'h05, 3, 0, 0);
    f = {8'h4A, 8'h08};
    frame(8'h80, me, 1'b0);
    ackon = 1'b1;
    e = {8'h08};
    rd(8'h4A, 1);
    for (int k = 0; k < 6; k++)
      wr(me, $random(seed) & 8'h1F, 1 + {$random(seed)} % 16, 0, 0);
    wr(me, 8'h00, 32, 0, 0);
    wr(8'hBF, 8'h14, 3, 1, 0);
    wr(me ^ 8'h80, 8'h02, 2, 0, 0);
    wr(idb(node ^ 6'h01), 8'h02, 2, 0, 0);
    wr(me, 8'h02, 2, 0, 1);
    chk(fault_pin_n_oe, 1'b0);
    repeat (130) @(negedge clk_sys);
    chk(fault_pin_n_oe, 1'b1);
    e = {8'h01};
    rd(8'h59, 1);
    e = {8'h01, 8'h58 ^ 8'h5A};
    rd(8'h57, 2);
    f = {8'h57, 8'h00};
    fault_report_delay = 4'h2;
    frame(8'h80, me, 1'b0);
    chk(fault_pin_n_oe, 1'b1);
    repeat (130) @(negedge clk_sys);
    chk(fault_pin_n_oe, 1'b1);
    repeat (130) @(negedge clk_sys);
    chk(fault_pin_n_oe, 1'b0);
    f = {8'h14};
    frame(8'hE0, 8'hBF, 1'b0);
    chk(16'(ufc_host_model_inst.got.size()), 16'h0);
    e = {8'h10 ^ 8'h5A, 8'h11 ^ 8'h5A};
    rd(8'h10, 2);
    frame(8'h98, me, 1'b0);
    chk(16'(n_upd), 16'h1);
    frame(8'hBE, 8'hBF, 1'b0);
    chk(16'(n_rst), 16'h1);
    e = {8'h00};
    rd(8'h4A, 1);
    end_sim;
  end
endmodule
